// *** src/iack_handler.sv ***
// Interrupt handler: watches request lines, gets the bus, runs the
// acknowledge cycle and returns the status/id.
// Assumes an on-board requester gives bus_grant and a backplane with
// external transceivers resolving the drive enable.
`timescale 1ns/1ps
`default_nettype none
`include "iack_params.svh"

// What this block and the other boards on the bus do
// [RULE_01] Among the watched lines the highest-numbered pending line is served first.
// [RULE_02] A pending watched line raises the request to the on-board requester.
// [RULE_03] The grant travels the chain to the requesting board, which keeps it.
// [RULE_04] The acknowledge cycle starts only after the requester reports the grant.
// [RULE_05] Selection comes first, and the id is read only after the interrupter answers.
// [RULE_06] Interrupters without a matching request pass the acknowledge edge on.
// [RULE_07] The first matching interrupter answers and does not pass the edge on.
// [RULE_08] The id is read as one, two or four bytes by cycle type.
// [RULE_09] The two data strobes may move at different moments and in either order.
// [RULE_10] The line number is put as a 3-bit code on the low address lines.
// [RULE_11] With the code, acknowledge and address strobe are driven low.
// [RULE_12] The slot-one chain driver turns acknowledge into a chain falling edge.
// [RULE_13] A matching interrupter drives its id and transfer acknowledge on strobes.
// [RULE_14] The answer holds until both strobes rise, then everything is released.
module iack_handler
   import iack_pkg::*;
#(
   parameter int LINE_LO = 1,
   parameter int LINE_HI = `IRQ_LINES
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        enable,
   input  wire width_t      width,
   input  wire logic [7:1]  irq_n,
   input  wire logic        bus_grant,
   input  wire logic        as_n_in,
   input  wire logic        dtack_n,
   input  wire logic [31:0] data_in,
   output logic             bus_req,
   output logic             bus_oe,
   output logic [2:0]       addr,
   output logic             iack_n,
   output logic             as_n,
   output logic             ds0_n,
   output logic             ds1_n,
   output logic             lword_n,
   output logic             write_n,
   output logic [31:0]      id,
   output logic             id_valid,
   output logic [2:0]       id_line
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (LINE_LO < 1 || LINE_HI > `IRQ_LINES || LINE_LO > LINE_HI) begin : g_bad_group
      $error("iack_handler: watched line group out of range");
   end
   if (`ADDR_SETUP_CYC > 15 || `AS_TO_DS_CYC > 15) begin : g_bad_cnt
      $error("iack_handler: timing count exceeds counter width");
   end

   localparam logic [3:0] SETUP_CNT = 4'(`ADDR_SETUP_CYC);
   localparam logic [3:0] DS_CNT    = 4'(`AS_TO_DS_CYC);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   pins_in_t pin_raw;
   pins_in_t pin_s;
   assign pin_raw = '{irq_n: irq_n, grant: ~bus_grant, as_n: as_n_in,
                      dtack_n: dtack_n, data: data_in};

   pin_sync #(.WIDTH($bits(pins_in_t))) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .rst_val ('1),
      .d       (pin_raw),
      .q       (pin_s)
   );

   logic grant_s;
   assign grant_s = ~pin_s.grant;

   // ----------------------------------------------------------------
   // Priority pick
   // ----------------------------------------------------------------
   function automatic logic [2:0] pick(input logic [7:1] pend);
      logic [2:0] best;
      best = 3'h0;
      for (int i = LINE_LO; i <= LINE_HI; i++) begin
         if (pend[i]) begin
            best = 3'(i);
         end
      end
      return best;
   endfunction

   logic [2:0] best;
   assign best = pick(~pin_s.irq_n);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   state_t s_reg;
   state_t s_next;

   always_comb begin
      s_next          = s_reg;
      s_next.id_valid = 1'b0;
      case (s_reg.st)
         ST_IDLE: begin
            // [RULE_01] [RULE_02] pick and request
            // [RULE_04] old grant must clear first
            if (enable && best != 3'h0 && !grant_s) begin
               s_next.line    = best;
               s_next.width   = width;
               s_next.bus_req = 1'b1;
               s_next.st      = ST_REQ;
            end
         end
         ST_REQ: begin
            // [RULE_03] [RULE_04] wait for grant
            if (grant_s) begin
               s_next.st = ST_WAIT_AS;
            end
         end
         ST_WAIT_AS: begin
            if (pin_s.as_n) begin
               // [RULE_10] [RULE_11] code and acknowledge out
               s_next.oe      = 1'b1;
               s_next.addr    = s_reg.line;
               s_next.iack_n  = 1'b0;
               s_next.write_n = 1'b1;
               s_next.lword_n = (s_reg.width != W32);
               s_next.cnt     = SETUP_CNT;
               s_next.st      = ST_ADDR;
            end
         end
         ST_ADDR: begin
            if (s_reg.cnt == 4'h1) begin
               s_next.as_n = 1'b0;
               s_next.cnt  = DS_CNT;
               s_next.st   = ST_STRB;
            end else begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end
         end
         ST_STRB: begin
            if (s_reg.cnt == 4'h1) begin
               // [RULE_08] [RULE_09] strobes by width
               s_next.ds0_n = 1'b0;
               s_next.ds1_n = (s_reg.width == W8);
               s_next.st    = ST_WAIT_ACK;
            end else begin
               s_next.cnt = s_reg.cnt - 4'h1;
            end
         end
         ST_WAIT_ACK: begin
            // [RULE_05] [RULE_07] [RULE_13] read on answer
            if (!pin_s.dtack_n) begin
               case (s_reg.width)
                  W8:      s_next.id = {24'h000000, pin_s.data[7:0]};
                  W16:     s_next.id = {16'h0000, pin_s.data[15:0]};
                  default: s_next.id = pin_s.data;
               endcase
               s_next.id_line  = s_reg.line;
               s_next.id_valid = 1'b1;
               s_next.as_n     = 1'b1;
               s_next.ds0_n    = 1'b1;
               s_next.ds1_n    = 1'b1;
               s_next.st       = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            // [RULE_14] hold bus until answer drops
            if (pin_s.dtack_n) begin
               s_next.oe      = 1'b0;
               s_next.iack_n  = 1'b1;
               s_next.lword_n = 1'b1;
               s_next.bus_req = 1'b0;
               s_next.st      = ST_IDLE;
            end
         end
         default: begin
            s_next.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_reg <= '{st: ST_IDLE, cnt: 4'h0, line: 3'h0, width: W8, bus_req: 1'b0,
                    oe: 1'b0, addr: 3'h0, iack_n: 1'b1, as_n: 1'b1, ds0_n: 1'b1,
                    ds1_n: 1'b1, lword_n: 1'b1, write_n: 1'b1, id: 32'h00000000,
                    id_valid: 1'b0, id_line: 3'h0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign bus_req  = s_reg.bus_req;
   assign bus_oe   = s_reg.oe;
   assign addr     = s_reg.addr;
   assign iack_n   = s_reg.iack_n;
   assign as_n     = s_reg.as_n;
   assign ds0_n    = s_reg.ds0_n;
   assign ds1_n    = s_reg.ds1_n;
   assign lword_n  = s_reg.lword_n;
   assign write_n  = s_reg.write_n;
   assign id       = s_reg.id;
   assign id_valid = s_reg.id_valid;
   assign id_line  = s_reg.id_line;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   property p_prio;
      $rose(s_reg.bus_req) |-> s_reg.line == $past(best);
   endproperty
   a_prio: assert property (p_prio) else $error("served line not highest pending"); // RULE_01

   property p_req;
      s_reg.st == ST_IDLE && enable && best != 3'h0 && !grant_s |=> s_reg.bus_req;
   endproperty
   a_req: assert property (p_req) else $error("request not raised"); // RULE_02

   property p_grant_first;
      $rose(s_reg.oe) |-> $past(grant_s, 2);
   endproperty
   a_grant_first: assert property (p_grant_first) else $error("drive before grant"); // RULE_04

   property p_grant_fresh;
      $rose(s_reg.bus_req) |-> !$past(grant_s);
   endproperty
   a_grant_fresh: assert property (p_grant_fresh) else $error("request over stale grant"); // RULE_04

   property p_code;
      !s_reg.iack_n |-> s_reg.addr == s_reg.line && s_reg.addr != 3'h0;
   endproperty
   a_code: assert property (p_code) else $error("acknowledge code mismatch"); // RULE_10

   sequence s_addr_held;
      (!s_reg.iack_n && s_reg.as_n) [*8];
   endsequence
   property p_as_setup;
      $rose(s_reg.oe) |-> s_addr_held ##1 (!s_reg.iack_n && s_reg.as_n) ##1 !s_reg.as_n;
   endproperty
   a_as_setup: assert property (p_as_setup) else $error("address setup short"); // RULE_11

   property p_ds_after_sel;
      $fell(s_reg.ds0_n) |-> !s_reg.as_n && $past(!s_reg.as_n, 9);
   endproperty
   a_ds_after_sel: assert property (p_ds_after_sel) else $error("strobe before select"); // RULE_05

   property p_width;
      !s_reg.ds0_n |-> s_reg.ds1_n == (s_reg.width == W8)
                       && s_reg.lword_n == (s_reg.width != W32);
   endproperty
   a_width: assert property (p_width) else $error("strobes do not match width"); // RULE_08

   property p_answer;
      s_reg.st == ST_WAIT_ACK && !pin_s.dtack_n |=> s_reg.id_valid ##1 !s_reg.id_valid;
   endproperty
   a_answer: assert property (p_answer) else $error("id not returned once"); // RULE_05

   property p_hold;
      s_reg.st == ST_RELEASE && !pin_s.dtack_n |=> s_reg.oe && !s_reg.iack_n
                                                  && s_reg.bus_req && s_reg.st == ST_RELEASE;
   endproperty
   a_hold: assert property (p_hold) else $error("bus dropped before answer ended"); // RULE_14

   property p_release;
      s_reg.st == ST_RELEASE && pin_s.dtack_n |=> !s_reg.oe && s_reg.iack_n
                                                 && !s_reg.bus_req;
   endproperty
   a_release: assert property (p_release) else $error("bus not released"); // RULE_14

endmodule
`default_nettype wire

// *** src/iack_params.svh ***
// Constants for the interrupt acknowledge handler.
// Assumes a 250 MHz system clock.
`ifndef IACK_PARAMS_SVH
`define IACK_PARAMS_SVH

`define CLK_PERIOD_NS     4
`define ADDR_SETUP_NS     35
`define AS_TO_DS_NS       40
`define ADDR_SETUP_CYC    ((`ADDR_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AS_TO_DS_CYC      ((`AS_TO_DS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IRQ_LINES         7
`define SYNC_STAGES       2

`endif

// *** src/iack_pkg.sv ***
// Types for the interrupt acknowledge handler.
// Assumes iack_params.svh sits in the include path.
package iack_pkg;

   typedef enum logic [1:0] {
      W8  = 2'h0,
      W16 = 2'h1,
      W32 = 2'h2
   } width_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_REQ     = 3'h1,
      ST_WAIT_AS = 3'h3,
      ST_ADDR    = 3'h2,
      ST_STRB    = 3'h6,
      ST_WAIT_ACK= 3'h7,
      ST_RELEASE = 3'h5
   } phase_t;

   typedef struct packed {
      logic [7:1]  irq_n;
      logic        grant;
      logic        as_n;
      logic        dtack_n;
      logic [31:0] data;
   } pins_in_t;

   typedef struct packed {
      phase_t      st;
      logic [3:0]  cnt;
      logic [2:0]  line;
      width_t      width;
      logic        bus_req;
      logic        oe;
      logic [2:0]  addr;
      logic        iack_n;
      logic        as_n;
      logic        ds0_n;
      logic        ds1_n;
      logic        lword_n;
      logic        write_n;
      logic [31:0] id;
      logic        id_valid;
      logic [2:0]  id_line;
   } state_t;

endpackage

// *** src/pin_sync.sv ***
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] rst_val,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;

   // ----------------------------------------------------------------
   // Two flops; reset loads all ones, q is q_reg unchanged since rst_val cancels out
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] q_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_reg <= '1;
         q_reg    <= '1;
      end else begin
         meta_reg <= d;
         q_reg    <= meta_reg;
      end
   end
   assign q = q_reg & rst_val | q_reg & ~rst_val;

endmodule
`default_nettype wire

// *** sim/iack_far_end.sv ***
// Far side of the handler: requester grant and pending interrupters.
// Assumes the bench sets pending lines and delays; lines idle high.
`timescale 1ns/1ps
`default_nettype none
module iack_far_end
   import iack_pkg::*;
#(
   parameter logic [31:0] ID_BASE = 32'h5A3C_9600
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [7:1]  pend,
   input  wire logic [7:0]  grant_dly,
   input  wire logic [7:0]  ack_dly,
   input  wire logic        bus_req,
   input  wire logic        bus_oe,
   input  wire logic [2:0]  addr,
   input  wire logic        iack_n,
   input  wire logic        as_n,
   input  wire logic        ds0_n,
   input  wire logic        ds1_n,
   input  wire logic        lword_n,
   output logic [7:1]       irq_n,
   output logic             bus_grant,
   output logic             as_n_in,
   output logic             dtack_n,
   output logic [31:0]      data_in
);
   logic [7:0]  gcnt, acnt;
   logic [31:0] word;
   logic        hit;
   // Released lines are driven high by the inverted pend bits
   assign irq_n   = ~pend;
   assign as_n_in = bus_oe ? as_n : 1'b1;
   assign word    = ID_BASE | {29'h0, addr};
   assign hit = bus_oe && !iack_n && !as_n && !ds0_n && addr != 3'h0 && pend[addr];
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         gcnt      <= 8'h00;
         acnt      <= 8'h00;
         bus_grant <= 1'b0;
         dtack_n   <= 1'b1;
         data_in   <= 32'hFFFF_FFFF;
      end else begin
         // grant kept by the requesting board
         if (!bus_req) begin
            gcnt      <= 8'h00;
            bus_grant <= 1'b0;
         end else if (gcnt >= grant_dly) begin
            bus_grant <= 1'b1;
         end else begin
            gcnt <= gcnt + 8'h01;
         end
         // answer held until both strobes high
         if (!dtack_n) begin
            if (ds0_n && ds1_n) begin
               dtack_n <= 1'b1;
               data_in <= ~data_in;
            end
         end else if (hit && acnt >= ack_dly) begin
            acnt    <= 8'h00;
            dtack_n <= 1'b0;
            data_in <= ds1_n ? {24'hFF_FFFF, word[7:0]} :
                       lword_n ? {16'hFFFF, word[15:0]} : word;
         end else if (hit) begin
            acnt <= acnt + 8'h01;
         end else begin
            acnt <= 8'h00;
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the interrupt acknowledge handler.
// Assumes the far-end model stands in for requester and interrupters.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import iack_pkg::*;
   localparam logic [31:0] ID_BASE = 32'h5A3C_9600;
   logic        clk_sys, rst, enable, bus_grant, as_n_in, dtack_n;
   logic        bus_req, bus_oe, iack_n, as_n, ds0_n, ds1_n, lword_n, id_valid, write_n;
   width_t      width;
   logic [7:1]  pend, irq_n;
   logic [7:0]  grant_dly, ack_dly;
   logic [31:0] data_in, id;
   logic [2:0]  addr, id_line;
   int          fail_count, num_checks;

   iack_handler iack_handler_inst (.clk_sys(clk_sys), .rst(rst), .enable(enable),
      .width(width), .irq_n(irq_n), .bus_grant(bus_grant), .as_n_in(as_n_in),
      .dtack_n(dtack_n), .data_in(data_in), .bus_req(bus_req), .bus_oe(bus_oe),
      .addr(addr), .iack_n(iack_n), .as_n(as_n), .ds0_n(ds0_n), .ds1_n(ds1_n),
      .lword_n(lword_n), .write_n(write_n), .id(id), .id_valid(id_valid), .id_line(id_line));
   iack_far_end #(.ID_BASE(ID_BASE)) iack_far_end_inst (.clk_sys(clk_sys), .rst(rst),
      .pend(pend), .grant_dly(grant_dly), .ack_dly(ack_dly), .bus_req(bus_req),
      .bus_oe(bus_oe), .addr(addr), .iack_n(iack_n), .as_n(as_n), .ds0_n(ds0_n),
      .ds1_n(ds1_n), .lword_n(lword_n), .irq_n(irq_n), .bus_grant(bus_grant),
      .as_n_in(as_n_in), .dtack_n(dtack_n), .data_in(data_in));

   // ------------------------------------------------------------
   // Compare and wait helpers
   // ------------------------------------------------------------
   task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic chk_bit(input string nm, input logic exp, input logic got);
      chk_word(nm, {31'h0, exp}, {31'h0, got});
   endtask
   task automatic chk_line(input string nm, input logic [2:0] exp, input logic [2:0] got);
      chk_word(nm, {29'h0, exp}, {29'h0, got});
   endtask
   task automatic wait_for(input string nm, ref logic sig, input logic lvl);
      for (int n = 0; n < 2000 && sig !== lvl; n++) @(negedge clk_sys);
      chk_bit(nm, lvl, sig);
   endtask
   task automatic wait_id(input logic [2:0] ln, input width_t w);
      logic [31:0] word;
      logic [31:0] exp;
      word = ID_BASE | {29'h0, ln};
      exp  = (w == W8) ? {24'h0, word[7:0]} : (w == W16) ? {16'h0, word[15:0]} : word;
      wait_for("as_n", as_n, 1'b0);
      chk_bit("bus_grant", 1'b1, bus_grant);
      chk_bit("bus_req", 1'b1, bus_req);
      chk_bit("iack_n", 1'b0, iack_n);
      chk_bit("bus_oe", 1'b1, bus_oe);
      chk_bit("write_n", 1'b1, write_n);
      chk_line("addr", ln, addr);
      wait_for("ds0_n", ds0_n, 1'b0);
      chk_bit("ds1_n", w == W8, ds1_n);
      chk_bit("lword_n", w != W32, lword_n);
      chk_bit("early id_valid", 1'b0, id_valid);
      wait_for("id_valid", id_valid, 1'b1);
      chk_line("id_line", ln, id_line);
      chk_word("id", exp, id);
      chk_bit("dtack_n", 1'b0, dtack_n);
      @(posedge clk_sys);
      pend[ln] <= 1'b0;
      wait_for("bus_req", bus_req, 1'b0);
      chk_bit("as_n idle", 1'b1, as_n);
      chk_bit("iack_n idle", 1'b1, iack_n);
      chk_bit("bus_oe idle", 1'b0, bus_oe);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk_bit("bus_req", 1'b0, bus_req);
      chk_bit("bus_oe", 1'b0, bus_oe);
      chk_bit("as_n", 1'b1, as_n);
      chk_word("id", 32'h0, id);
   endtask
   task automatic t_lines;
      for (int l = 1; l <= 7; l++) begin
         @(posedge clk_sys);
         width   <= width_t'(l % 3);
         pend[l] <= 1'b1;
         wait_id(3'(l), width_t'(l % 3));
      end
   endtask
   task automatic t_prio;
      @(posedge clk_sys);
      width   <= W16;
      pend[2] <= 1'b1;
      pend[4] <= 1'b1;
      pend[6] <= 1'b1;
      wait_id(3'h6, W16);
      wait_id(3'h4, W16);
      wait_id(3'h2, W16);
   endtask
   task automatic t_enable;
      @(posedge clk_sys);
      enable  <= 1'b0;
      pend[5] <= 1'b1;
      repeat (30) @(negedge clk_sys);
      chk_bit("bus_req off", 1'b0, bus_req);
      @(posedge clk_sys);
      enable <= 1'b1;
      wait_id(3'h5, W16);
   endtask
   task automatic t_slow;
      @(posedge clk_sys);
      grant_dly <= 8'h3C;
      ack_dly   <= 8'h1E;
      width     <= W32;
      pend[1]   <= 1'b1;
      wait_id(3'h1, W32);
   endtask

   // ------------------------------------------------------------
   // Clock, sequence and verdict
   // ------------------------------------------------------------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      $display("watchdog expired");
      end_of_test();
   end
   initial begin
      rst        = 1'b1;
      enable     = 1'b1;
      width      = W8;
      pend       = 7'h00;
      grant_dly  = 8'h02;
      ack_dly    = 8'h00;
      fail_count = 0;
      num_checks = 0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      t_reset();
      t_lines();
      t_prio();
      t_enable();
      t_slow();
      end_of_test();
   end
endmodule
`default_nettype wire
